//--- hdl/dbac_pkg.sv
// package: constants and carriers for the dual boost adaptive control block
package dbac_pkg;

  // ----------------------------------------------------------------
  // clock and switching timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ          = 40_000_000;
  localparam int unsigned FSW_SLOW_KHZ    = 500;
  localparam int unsigned FSW_FAST_KHZ    = 1000;
  localparam int unsigned PERIOD_SLOW_CYC = CLK_HZ / (FSW_SLOW_KHZ * 1000);
  localparam int unsigned PERIOD_FAST_CYC = CLK_HZ / (FSW_FAST_KHZ * 1000);
  localparam int unsigned PW              = 8;

  // ----------------------------------------------------------------
  // setpoint coding: one code step per 100 mV
  // ----------------------------------------------------------------
  localparam int unsigned VW             = 9;
  localparam int unsigned MV_PER_STEP    = 100;
  localparam int unsigned CEIL_MIN_MV    = 18000;
  localparam int unsigned CEIL_MAX_MV    = 28000;
  localparam int unsigned OVP_MARGIN_MV  = 1600;
  localparam logic [VW-1:0] CEIL_MIN_CODE = VW'(CEIL_MIN_MV / MV_PER_STEP);
  localparam logic [VW-1:0] CEIL_MAX_CODE = VW'(CEIL_MAX_MV / MV_PER_STEP);
  localparam logic [VW-1:0] OVP_CODE      = VW'(OVP_MARGIN_MV / MV_PER_STEP);
  localparam logic [VW-1:0] SETPOINT_RST  = 9'h000;

  // ----------------------------------------------------------------
  // loop timing and soft start
  // ----------------------------------------------------------------
  localparam int unsigned UPDATE_US       = 50;
  localparam int unsigned UPDATE_CYC      = UPDATE_US * (CLK_HZ / 1_000_000);
  localparam int unsigned SOFTSTART_US    = 1000;
  localparam int unsigned SOFTSTART_CYC   = SOFTSTART_US * (CLK_HZ / 1_000_000);
  localparam int unsigned SPREAD_W        = 4;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    DBAC_IDLE  = 3'b001,
    DBAC_SOFT  = 3'b010,
    DBAC_RUN   = 3'b100
  } dbac_state_t;

  typedef struct packed {
    logic          boost_freq_select;
    logic          spread_en;
    logic [1:0]    slew_sel;
    logic [VW-1:0] initial_boost_setpoint;
    logic [VW-1:0] boost_voltage_ceiling;
  } dbac_cfg_t;

  typedef struct packed {
    logic       gate;
    logic [3:0] drv_en;
    logic       soft_limit;
  } dbac_sw_t;

endpackage

//--- hdl/dbac_bank_loop.sv
// one bank's adaptive setpoint loop and overvoltage stop
module dbac_bank_loop
  import dbac_pkg::*;
#(
  parameter int unsigned STRINGS = 6
) (
  // clock and reset
  input  wire logic               clk_sys_i,
  input  wire logic               rst_n_i,
  input  wire logic               ce_i,
  // control
  input  wire logic               load_i,
  input  wire logic               tick_i,
  input  wire logic [VW-1:0]      init_i,
  input  wire logic [VW-1:0]      ceil_i,
  // headroom and output sense
  input  wire logic [STRINGS-1:0] low_i,
  input  wire logic [STRINGS-1:0] mid_i,
  input  wire logic [VW-1:0]      vout_i,
  // results
  output logic      [VW-1:0]      setpoint_o,
  output logic                    ovp_o,
  output logic                    raise_o,
  output logic                    lower_o
);

  initial begin
    if (STRINGS < 1 || STRINGS > 16) $error("dbac_bank_loop: STRINGS out of range");
  end

  logic [STRINGS-1:0] low_r;
  logic [STRINGS-1:0] mid_r;
  logic [VW-1:0]      setpoint_r;
  logic               ovp_r;
  logic               want_up;
  logic               want_dn;
  logic [VW:0]        ovp_lim;

  // ----------------------------------------------------------------
  // comparator sampling
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      low_r <= '0;
      mid_r <= '0;
    end else if (ce_i) begin
      low_r <= low_i;
      mid_r <= mid_i;
    end
  end

  assign want_up = |low_r;
  assign want_dn = &mid_r;

  // ----------------------------------------------------------------
  // setpoint
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      setpoint_r <= SETPOINT_RST;
    end else if (ce_i) begin
      if (load_i) begin
        setpoint_r <= (init_i > ceil_i) ? ceil_i : init_i;
      end else if (tick_i && want_up) begin
        if (setpoint_r < ceil_i) begin
          setpoint_r <= setpoint_r + 9'h001;
        end
      end else if (tick_i && want_dn && setpoint_r != '0) begin
        setpoint_r <= setpoint_r - 9'h001;
      end
    end
  end

  // ----------------------------------------------------------------
  // overvoltage stop tracks the setpoint
  // ----------------------------------------------------------------
  assign ovp_lim = {1'b0, setpoint_r} + {1'b0, OVP_CODE};

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ovp_r <= 1'b0;
    end else if (ce_i) begin
      ovp_r <= ({1'b0, vout_i} > ovp_lim);
    end
  end

  assign setpoint_o = setpoint_r;
  assign ovp_o      = ovp_r;
  assign raise_o    = want_up;
  assign lower_o    = want_dn & ~want_up;

  a_ceiling_held: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    !load_i |=> (setpoint_r <= ceil_i) || ($past(setpoint_r) > $past(ceil_i)))
    else $error("setpoint above ceiling");

endmodule

//--- hdl/dbac_top.sv
// top: dual boost adaptive control, clocking, slew, spread, soft start
//
// What this block does
// - switching period is 500 kHz when the frequency select is 0 and 1000 kHz when it is 1.
// - bank B's switch clock starts half a period after bank A's so they never turn on together.
// - a bank's setpoint goes up when any of its strings is below the low headroom threshold.
// - a bank's setpoint goes down only when all its strings are above the middle threshold.
// - each bank has its own setpoint loop fed only by its own strings.
// - each setpoint is loaded with the initial value, clamped to the ceiling, when boost operation begins.
// - the setpoint never climbs past the programmed ceiling of 18 to 28 volts.
// - switching stops while the output is more than 1.6 volts above the setpoint.
// - both switches use one to four parallel driver enables chosen by one shared setting.
// - spread spectrum optionally varies the switching period over time.
// - a soft-start phase at start-up lowers the permitted peak inductor current.
//
// Design decisions made here: the register addresses and strobed register access.
module dbac_top
  import dbac_pkg::*;
#(
  parameter int unsigned STRINGS       = 6,
  parameter int unsigned UPDATE_CYCLES = UPDATE_CYC,
  parameter int unsigned SOFT_CYCLES   = SOFTSTART_CYC
) (
  // clock and reset
  input  wire logic               clk_sys_i,
  input  wire logic               rst_n_i,
  input  wire logic               ce_i,
  // run control and configuration
  input  wire logic               boost_en_i,
  input  wire dbac_cfg_t          cfg_i,
  // bank A sense
  input  wire logic [STRINGS-1:0] a_low_i,
  input  wire logic [STRINGS-1:0] a_mid_i,
  input  wire logic [VW-1:0]      a_vout_i,
  // bank B sense
  input  wire logic [STRINGS-1:0] b_low_i,
  input  wire logic [STRINGS-1:0] b_mid_i,
  input  wire logic [VW-1:0]      b_vout_i,
  // register port
  input  wire logic [3:0]         reg_addr_i,
  input  wire logic [15:0]        reg_wdata_i,
  input  wire logic               reg_wr_i,
  input  wire logic               reg_rd_i,
  output logic      [15:0]        reg_rdata_o,
  // power stage drive
  output dbac_sw_t                sw_a_o,
  output dbac_sw_t                sw_b_o,
  output logic      [VW-1:0]      setpoint_a_o,
  output logic      [VW-1:0]      setpoint_b_o,
  // interrupt
  output logic                    irq_o
);

  localparam logic [3:0] ADDR_STATUS = 4'h0;
  localparam logic [3:0] ADDR_MASK   = 4'h1;
  localparam logic [3:0] ADDR_SETPT  = 4'h2;
  localparam logic [3:0] ADDR_STATE  = 4'h3;
  localparam int unsigned EVW        = 4;
  localparam int unsigned UCW        = $clog2(UPDATE_CYCLES + 1);
  localparam int unsigned SCW        = $clog2(SOFT_CYCLES + 1);

  initial begin
    if (UPDATE_CYCLES < 1) $error("dbac_top: UPDATE_CYCLES must be positive");
    if (SOFT_CYCLES < 1) $error("dbac_top: SOFT_CYCLES must be positive");
    if (PERIOD_SLOW_CYC + 15 > 255) $error("dbac_top: period counter too narrow");
  end

  function automatic logic [3:0] slew_mask(input logic [1:0] sel);
    logic [3:0] m;
    m = 4'h0;
    case (sel)
      2'h0:    m = 4'h1;
      2'h1:    m = 4'h3;
      2'h2:    m = 4'h7;
      default: m = 4'hf;
    endcase
    return m;
  endfunction

  // ----------------------------------------------------------------
  // run state: idle, soft start, run
  // ----------------------------------------------------------------
  dbac_state_t state_r;
  logic [SCW-1:0] soft_cnt_r;
  logic load_pulse;

  assign load_pulse = (state_r == DBAC_IDLE) && boost_en_i;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r    <= DBAC_IDLE;
      soft_cnt_r <= '0;
    end else if (ce_i) begin
      case (state_r)
        DBAC_IDLE: begin
          soft_cnt_r <= '0;
          if (boost_en_i) begin
            state_r <= DBAC_SOFT;
          end
        end
        DBAC_SOFT: begin
          if (!boost_en_i) begin
            state_r <= DBAC_IDLE;
          end else if (soft_cnt_r == SCW'(SOFT_CYCLES - 1)) begin
            state_r <= DBAC_RUN;
          end else begin
            soft_cnt_r <= soft_cnt_r + SCW'(1);
          end
        end
        DBAC_RUN: begin
          if (!boost_en_i) begin
            state_r <= DBAC_IDLE;
          end
        end
        default: state_r <= DBAC_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // switching period with optional spread
  // ----------------------------------------------------------------
  logic [PW-1:0]       per_cnt_r;
  logic [PW-1:0]       period;
  logic [PW-1:0]       half;
  logic [SPREAD_W-1:0] lfsr_r;
  logic                wrap;

  always_comb begin
    period = cfg_i.boost_freq_select ? PW'(PERIOD_FAST_CYC) : PW'(PERIOD_SLOW_CYC);
    if (cfg_i.spread_en) begin
      period = period + PW'(lfsr_r);
    end
    half = period >> 1;
  end

  assign wrap = (per_cnt_r >= period - PW'(1));

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      per_cnt_r <= '0;
    end else if (ce_i) begin
      if (state_r == DBAC_IDLE || wrap) begin
        per_cnt_r <= '0;
      end else begin
        per_cnt_r <= per_cnt_r + PW'(1);
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lfsr_r <= 4'h1;
    end else if (ce_i && wrap) begin
      lfsr_r <= {lfsr_r[2:0], lfsr_r[3] ^ lfsr_r[2]};
    end
  end

  // ----------------------------------------------------------------
  // control update tick
  // ----------------------------------------------------------------
  logic [UCW-1:0] upd_cnt_r;
  logic           tick;

  assign tick = (upd_cnt_r == UCW'(UPDATE_CYCLES - 1)) && (state_r != DBAC_IDLE);

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      upd_cnt_r <= '0;
    end else if (ce_i) begin
      if (state_r == DBAC_IDLE || tick) begin
        upd_cnt_r <= '0;
      end else begin
        upd_cnt_r <= upd_cnt_r + UCW'(1);
      end
    end
  end

  // ----------------------------------------------------------------
  // per bank loops
  // ----------------------------------------------------------------
  logic [VW-1:0] ceil_eff;
  logic ovp_a, ovp_b, up_a, up_b, dn_a, dn_b;

  always_comb begin
    ceil_eff = cfg_i.boost_voltage_ceiling;
    if (ceil_eff < CEIL_MIN_CODE) begin
      ceil_eff = CEIL_MIN_CODE;
    end else if (ceil_eff > CEIL_MAX_CODE) begin
      ceil_eff = CEIL_MAX_CODE;
    end
  end

  // separate instances keep the banks from ever seeing each other's strings
  dbac_bank_loop #(.STRINGS(STRINGS)) u_bank_a (
    .clk_sys_i  (clk_sys_i),
    .rst_n_i    (rst_n_i),
    .ce_i       (ce_i),
    .load_i     (load_pulse),
    .tick_i     (tick),
    .init_i     (cfg_i.initial_boost_setpoint),
    .ceil_i     (ceil_eff),
    .low_i      (a_low_i),
    .mid_i      (a_mid_i),
    .vout_i     (a_vout_i),
    .setpoint_o (setpoint_a_o),
    .ovp_o      (ovp_a),
    .raise_o    (up_a),
    .lower_o    (dn_a)
  );

  dbac_bank_loop #(.STRINGS(STRINGS)) u_bank_b (
    .clk_sys_i  (clk_sys_i),
    .rst_n_i    (rst_n_i),
    .ce_i       (ce_i),
    .load_i     (load_pulse),
    .tick_i     (tick),
    .init_i     (cfg_i.initial_boost_setpoint),
    .ceil_i     (ceil_eff),
    .low_i      (b_low_i),
    .mid_i      (b_mid_i),
    .vout_i     (b_vout_i),
    .setpoint_o (setpoint_b_o),
    .ovp_o      (ovp_b),
    .raise_o    (up_b),
    .lower_o    (dn_b)
  );

  // ----------------------------------------------------------------
  // switch drive
  // ----------------------------------------------------------------
  logic gate_a_r, gate_b_r;
  logic running;

  assign running = (state_r != DBAC_IDLE);

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gate_a_r <= 1'b0;
      gate_b_r <= 1'b0;
    end else if (ce_i) begin
      // on-time is the first quarter period for A and the third quarter for B; the bank's overvoltage stop blocks it
      gate_a_r <= running && !ovp_a && (per_cnt_r < (half >> 1));
      gate_b_r <= running && !ovp_b && (per_cnt_r >= half)
                  && (per_cnt_r < half + (half >> 1));
    end
  end

  always_comb begin
    sw_a_o.gate       = gate_a_r;
    sw_b_o.gate       = gate_b_r;
    sw_a_o.drv_en     = running ? slew_mask(cfg_i.slew_sel) : 4'h0;
    sw_b_o.drv_en     = running ? slew_mask(cfg_i.slew_sel) : 4'h0;
    sw_a_o.soft_limit = (state_r == DBAC_SOFT);
    sw_b_o.soft_limit = (state_r == DBAC_SOFT);
  end

  // ----------------------------------------------------------------
  // events, status, mask, register port
  // ----------------------------------------------------------------
  logic [EVW-1:0] status_r;
  logic [EVW-1:0] mask_r;
  logic [EVW-1:0] events;
  logic [EVW-1:0] w1c;
  logic [15:0]    rdata_r;
  logic           at_ceil;

  assign at_ceil = (setpoint_a_o >= ceil_eff) && up_a || (setpoint_b_o >= ceil_eff) && up_b;
  assign events  = {at_ceil, ovp_b, ovp_a, (state_r == DBAC_SOFT) && soft_cnt_r
                   == SCW'(SOFT_CYCLES - 1)};
  assign w1c     = (reg_wr_i && reg_addr_i == ADDR_STATUS) ? reg_wdata_i[EVW-1:0] : '0;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      status_r <= '0;
    end else if (ce_i) begin
      // a new event in the clearing cycle survives
      status_r <= (status_r & ~w1c) | events;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mask_r <= '0;
    end else if (ce_i && reg_wr_i && reg_addr_i == ADDR_MASK) begin
      mask_r <= reg_wdata_i[EVW-1:0];
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_r <= 16'h0000;
    end else if (ce_i) begin
      rdata_r <= 16'h0000;
      if (reg_rd_i) begin
        if (reg_addr_i == ADDR_STATUS) begin
          rdata_r <= {12'h000, status_r};
        end else if (reg_addr_i == ADDR_MASK) begin
          rdata_r <= {12'h000, mask_r};
        end else if (reg_addr_i == ADDR_SETPT) begin
          rdata_r <= {7'h00, setpoint_a_o};
        end else if (reg_addr_i == ADDR_STATE) begin
          rdata_r <= {7'h00, setpoint_b_o};
        end
      end
    end
  end

  assign reg_rdata_o = rdata_r;
  assign irq_o       = |(status_r & mask_r);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_no_overlap: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    !(gate_a_r && gate_b_r))
    else $error("both switches on together");
  a_ovp_stops: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    ce_i && ovp_a |=> !gate_a_r)
    else $error("bank A switched during overvoltage");
  a_soft_limit: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    sw_a_o.soft_limit == (state_r == DBAC_SOFT) && sw_a_o.drv_en == sw_b_o.drv_en)
    else $error("soft limit or driver choice mismatch");
  a_drv_count: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    running && cfg_i.slew_sel == 2'h0 |-> sw_a_o.drv_en == 4'h1)
    else $error("slowest slew not one driver");
  a_load_init: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    ce_i && load_pulse && cfg_i.initial_boost_setpoint <= ceil_eff
    |=> setpoint_a_o == $past(cfg_i.initial_boost_setpoint))
    else $error("setpoint not loaded at start");
  a_one_step: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    !$past(load_pulse) |-> (setpoint_a_o - $past(setpoint_a_o) <= 9'h001)
    || ($past(setpoint_a_o) - setpoint_a_o <= 9'h001))
    else $error("setpoint moved more than one step");
  a_raise_first: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    ce_i && tick && up_b && setpoint_b_o < ceil_eff && !load_pulse
    |=> setpoint_b_o == $past(setpoint_b_o) + 9'h001)
    else $error("bank B did not raise");
  a_lower_all: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    ce_i && tick && !dn_a && !up_a && !load_pulse |=> $stable(setpoint_a_o))
    else $error("bank A lowered without all strings high");
  a_fast_period: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    !cfg_i.spread_en && cfg_i.boost_freq_select |-> period == PW'(PERIOD_FAST_CYC))
    else $error("wrong fast period");

  c_run: cover property (@(posedge clk_sys_i) state_r == DBAC_SOFT ##1 state_r == DBAC_RUN);
  c_raise: cover property (@(posedge clk_sys_i) tick && up_a);
  c_ovp: cover property (@(posedge clk_sys_i) ovp_b);

endmodule

//--- test/dbac_stage_model.sv
// behavioural boost stage and led string bank for one converter
module dbac_stage_model
  import dbac_pkg::*;
#(
  parameter int unsigned STRINGS = 6
) (
  // clock
  input  wire logic               clk_sys_i,
  // setpoint from the block
  input  wire logic [VW-1:0]      setpoint_i,
  // test controls
  input  wire logic [VW-1:0]      need_i,
  input  wire logic [VW-1:0]      extra_i,
  input  wire logic               open_i,
  // sense back to the block
  output logic      [STRINGS-1:0] low_o,
  output logic      [STRINGS-1:0] mid_o,
  output logic      [VW-1:0]      vout_o
);
  // output lags the setpoint by a cycle; extra_i injects an overshoot
  always_ff @(posedge clk_sys_i) begin
    vout_o <= setpoint_i + extra_i;
  end

  // string k needs need_i+k; the middle band sits four codes higher
  // an open string never gets headroom, so it always asks for more
  always_comb begin
    for (int k = 0; k < STRINGS; k++) begin
      low_o[k] = (vout_o < need_i + VW'(k)) || (open_i && k == 0);
      mid_o[k] = (vout_o > need_i + VW'(k) + 9'h004) && !(open_i && k == 0);
    end
  end
endmodule

//--- test/testbench.sv
// self-checking bench for the dual boost adaptive control block
module testbench
  import dbac_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // --------
  // signals
  // --------
  localparam int UPD  = 4;
  localparam int SOFT = 20;
  logic          clk_sys_i   = 1'b0;
  logic          rst_n_i     = 1'b0;
  logic          boost_en_i  = 1'b0;
  dbac_cfg_t     cfg_i       = '0;
  logic [3:0]    reg_addr_i  = 4'h0;
  logic [15:0]   reg_wdata_i = 16'h0000;
  logic          reg_wr_i    = 1'b0;
  logic          reg_rd_i    = 1'b0;
  logic [VW-1:0] need_a      = 9'h0c8;
  logic [VW-1:0] need_b      = 9'h0c8;
  logic [VW-1:0] ext_a       = 9'h000;
  logic [VW-1:0] ext_b       = 9'h000;
  logic          ce_i        = 1'b1;
  logic          open_a      = 1'b0;
  logic [5:0]    a_low, a_mid, b_low, b_mid;
  logic [VW-1:0] a_vout, b_vout, sp_a, sp_b;
  logic [15:0]   reg_rdata_o, rdata;
  dbac_sw_t      sw_a, sw_b;
  logic          irq;
  int            fail_count = 0;
  int            n_tests    = 0;
  int            cyc        = 0;
  int            lst        = 0;
  int            pa         = 0;
  int            na, nb, cv, ra, rb;

  initial forever #12.5 clk_sys_i = ~clk_sys_i;

  dbac_top #(.STRINGS(6), .UPDATE_CYCLES(UPD), .SOFT_CYCLES(SOFT)) dut (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .boost_en_i(boost_en_i),
    .cfg_i(cfg_i), .a_low_i(a_low), .a_mid_i(a_mid), .a_vout_i(a_vout),
    .b_low_i(b_low), .b_mid_i(b_mid), .b_vout_i(b_vout), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .sw_a_o(sw_a), .sw_b_o(sw_b), .setpoint_a_o(sp_a),
    .setpoint_b_o(sp_b), .irq_o(irq));
  dbac_stage_model ua (.clk_sys_i(clk_sys_i), .setpoint_i(sp_a), .need_i(need_a),
    .extra_i(ext_a), .open_i(open_a), .low_o(a_low), .mid_o(a_mid), .vout_o(a_vout));
  dbac_stage_model ub (.clk_sys_i(clk_sys_i), .setpoint_i(sp_b), .need_i(need_b),
    .extra_i(ext_b), .open_i(1'b0), .low_o(b_low), .mid_o(b_mid), .vout_o(b_vout));

  // --------
  // checks and bus tasks
  // --------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_in(input logic [31:0] got, input int lo, input int hi);
    n_tests++;
    if (!((got >= lo) === 1'b1 && (got <= hi) === 1'b1)) begin
      fail_count++;
      $display("FAIL t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_i    <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd_i   <= 1'b0;
    @(negedge clk_sys_i);
    d = reg_rdata_o;
  endtask

  // reset, configure, enable; expected load is init clamped to the ceiling
  task automatic start(input logic fs, input logic sp, input logic [1:0] sl,
                       input int init, input int ceil_v);
    int cl;
    int e;
    @(posedge clk_sys_i);
    rst_n_i    <= 1'b0;
    boost_en_i <= 1'b0;
    repeat (16) @(posedge clk_sys_i);
    cfg_i   <= '{fs, sp, sl, VW'(init), VW'(ceil_v)};
    rst_n_i <= 1'b1;
    @(posedge clk_sys_i);
    boost_en_i <= 1'b1;
    cl = ceil_v < 180 ? 180 : (ceil_v > 280 ? 280 : ceil_v);
    e  = init < cl ? init : cl;
    for (int i = 0; i < 8 && sp_a == 9'h000; i++) @(negedge clk_sys_i);
    chk(16'(sp_a), 16'(e));
    chk(16'(sp_b), 16'(e));
    chk({14'h0, sw_a.soft_limit, sw_b.soft_limit}, 16'h0003);
    chk(16'($countones(sw_a.drv_en)), 16'(sl) + 16'h0001);
    chk(16'($countones(sw_b.drv_en)), 16'(sl) + 16'h0001);
  endtask

  // period of bank A and the delay of bank B's turn-on behind it
  task automatic meas(input int p, input logic sp);
    int t0, mn, mx;
    mn = 1000;
    mx = 0;
    @(posedge sw_a.gate);
    repeat (6) begin
      t0 = cyc;
      @(posedge sw_b.gate);
      if (!sp) chk(16'(cyc - t0), 16'(p / 2));
      @(posedge sw_a.gate);
      if (!sp) chk(16'(cyc - t0), 16'(p));
      else chk_in(32'(cyc - t0), p, p + 15);
      mn = (cyc - t0) < mn ? cyc - t0 : mn;
      mx = (cyc - t0) > mx ? cyc - t0 : mx;
    end
    if (sp) chk({15'h0, mx != mn}, 16'h0001);
  endtask

  // --------
  // monitors
  // --------
  always @(negedge clk_sys_i) begin
    cyc++;
    if (sw_a.gate === 1'b1) chk({15'h0, sw_b.gate}, 16'h0000);
    if (pa != 0 && sp_a != 9'h000 && sp_a != pa) begin
      chk_in(32'(cyc - lst), UPD, 1 << 20);
      chk_in(32'(sp_a > pa ? sp_a - pa : pa - sp_a), 1, 1);
      lst = cyc;
    end
    pa = sp_a;
  end

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    #(25.0 * 60000);
    fail_count++;
    end_sim();
  end

  // --------
  // tests
  // --------
  initial begin
    void'($urandom(32'hb314));
    for (int i = 0; i < 4; i++) begin
      start(i[0], i[1], 2'(i), 100 + $urandom % 200, 150 + $urandom % 180);
      meas(i[0] ? 40 : 80, i[1]);
      chk({14'h0, sw_a.soft_limit, sw_b.soft_limit}, 16'h0000);
      rd(4'h0, rdata);
      chk(rdata & 16'h0001, 16'h0001);
      $display("test clocking %0d done", i);
    end
    na = 150 + $urandom % 60;
    nb = 150 + $urandom % 60;
    need_a <= 9'(na);
    need_b <= 9'(nb);
    start(1'b0, 1'b0, 2'h3, 185, 280);
    repeat (800) @(negedge clk_sys_i);
    chk_in(32'(sp_a), na + 5, na + 9);
    chk_in(32'(sp_b), nb + 5, nb + 9);
    rd(4'h3, rdata);
    chk_in(32'(rdata), nb + 5, nb + 9);
    rd(4'h2, rdata);
    chk_in(32'(rdata), na + 5, na + 9);
    $display("test adaptive done");
    cv = 190 + $urandom % 60;
    open_a <= 1'b1;
    start(1'b1, 1'b0, 2'h1, 185, cv);
    @(posedge clk_sys_i);
    ce_i <= 1'b0;
    repeat (40) @(negedge clk_sys_i);
    chk(16'(sp_a), 16'h00b9);
    @(posedge clk_sys_i);
    ce_i <= 1'b1;
    repeat (800) @(negedge clk_sys_i);
    chk(16'(sp_a), 16'(cv));
    chk_in(32'(sp_b), nb + 5, nb + 9);
    rd(4'h0, rdata);
    chk(rdata & 16'h0008, 16'h0008);
    chk({15'h0, irq}, 16'h0000);
    wr(4'h1, 16'h0008);
    @(negedge clk_sys_i);
    chk({15'h0, irq}, 16'h0001);
    wr(4'h1, 16'h0000);
    @(negedge clk_sys_i);
    chk({15'h0, irq}, 16'h0000);
    open_a <= 1'b0;
    repeat (400) @(negedge clk_sys_i);
    wr(4'h0, 16'hffff);
    rd(4'h0, rdata);
    chk(rdata & 16'h0009, 16'h0000);
    rd(4'hf, rdata);
    chk(rdata, 16'h0000);
    $display("test ceiling done");
    start(1'b1, 1'b0, 2'h0, 200, 280);
    ext_a <= 9'h011;
    repeat (20) @(negedge clk_sys_i);
    ra = 0;
    rb = 0;
    repeat (200) begin
      @(negedge clk_sys_i);
      ra += sw_a.gate;
      rb += sw_b.gate;
    end
    chk(16'(ra), 16'h0000);
    chk_in(32'(rb), 1, 200);
    rd(4'h0, rdata);
    chk(rdata & 16'h0006, 16'h0002);
    ext_a <= 9'h010;
    ra = 0;
    repeat (200) begin
      @(negedge clk_sys_i);
      ra += sw_a.gate;
    end
    chk_in(32'(ra), 1, 200);
    ext_b <= 9'h011;
    repeat (10) @(negedge clk_sys_i);
    rd(4'h0, rdata);
    chk(rdata & 16'h0004, 16'h0004);
    $display("test overvoltage done");
    end_sim();
  end
endmodule
